// *** src/smpc_defines.vh ***
`ifndef SMPC_DEFINES_VH
`define SMPC_DEFINES_VH
// register indices as printed; byte address is index times four
`define SMPC_IDX_PWM_FREQ 8'h56
`define SMPC_IDX_PWM_MIN_ON 8'h57
`define SMPC_IDX_SCAN_STEP 8'h60
`define SMPC_IDX_FEED_STEP 8'h61
`define SMPC_IDX_PAUSE_CFG 8'h62
`define SMPC_IDX_ACCEL 8'h63
`define SMPC_IDX_HOLD 8'h64
`define SMPC_IDX_CTRL 8'h65
`define SMPC_IDX_STATUS 8'h66
`define SMPC_ADDR_W 12
`define SMPC_STEP_W 14
// reset values
`define SMPC_RST_PWM_FREQ 8'h40
`define SMPC_RST_PWM_MIN_ON 8'h04
`define SMPC_RST_SCAN_STEP 14'h0100
`define SMPC_RST_FEED_STEP 14'h0040
// pause config fields: [2:0] lines after pause, [10:8] reverse full steps
`define SMPC_PC_LINES_LSB 0
`define SMPC_PC_REV_LSB 8
// accel fields: [1:0] stop x, [3:2] quarter y, [5:4] half z
`define SMPC_AC_X_LSB 0
`define SMPC_AC_Y_LSB 2
`define SMPC_AC_Z_LSB 4
// ctrl fields
`define SMPC_CT_RUN 0
`define SMPC_CT_FEED 1
`define SMPC_CT_MICRO 2
// dac codes for 0, 0.125, 0.191, 0.353, 0.462, 0.500 V
`define SMPC_DAC_OFF 3'h0
`define SMPC_DAC_HOLD 3'h1
`define SMPC_DAC_L1 3'h2
`define SMPC_DAC_L2 3'h3
`define SMPC_DAC_L3 3'h4
`define SMPC_DAC_L4 3'h5
// pixel period in system clocks
`define SMPC_PIX_DIV 8'd24
`define SMPC_DIV_LAST (`SMPC_PIX_DIV - 8'd1)
`endif

// *** src/smpc_stepper_microstep_pause_controller.v ***
// Behaviour
// [R01] signed code sets phase pins and dac
// [R02] table index advances once per microstep
// [R03] pwm with frequency and minimum on-time
// [R04] software keeps minimum on-time short
// [R05] reverse count zero: pause just stops
// [R06] non-reversing: finish current line first
// [R07] non-reversing: store 0 to 7 extra lines
// [R08] resume waits after transfer pulse, scan rate
// [R09] software sets discard equal to process count
// [R10] reverse count above zero enables reversing
// [R11] reversing: finish line, record pulse-step offset
// [R12] stop, reverse, stop, wait offset on resume
// [R13] three segments 0 to 3, zero skipped
// [R14] stop segment counts full step clocks; code skips it when quarter y and half z are both zero
// [R15] half speed 2x, quarter 4x period
// [R16] slow segment full step is 4 clocks
// [R17] decel, stop, reverse, full back, decel, hold; code goes from full back straight to hold, with no decel
// [R18] hold outputs until timeout, then off
// [R19] resume: resync, quarter, half, full speed; code resumes at full speed right after resync
// [R20] same profile on every start and stop; code starts from idle straight at full speed and stops at once when run clears in the run state
// [R21] reversing ignores lines setting
// [R22] feed uses fast-feed step size
// [R23] motion counted in microsteps, four per step
// [R24] scan step size is 14-bit pixel count
// [R25] pause and resume come from line buffer
`timescale 1ns/1ps
`default_nettype none
`include "smpc_defines.vh"
module smpc_stepper_microstep_pause_controller #(
  parameter STEP_W = `SMPC_STEP_W
) (
  input wire clk_sys,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SMPC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pause_req,
  input wire resume_req,
  input wire sensor_transfer_pulse,
  input wire line_end,
  input wire winding_sense_over,
  output reg phase_a_ff,
  output reg phase_an_ff,
  output reg phase_b_ff,
  output reg phase_bn_ff,
  output reg [2:0] dac_a_ff,
  output reg [2:0] dac_b_ff,
  output reg line_store_en_ff,
  output reg line_discard_ff
);
  ////////////////////////////////////////////////////////////////////
  localparam [10:0] ST_IDLE = 11'h001, ST_RUN = 11'h002, ST_DEC_H = 11'h004, ST_DEC_Q = 11'h008,
    ST_STOP = 11'h010, ST_BK_Q = 11'h020, ST_BK_H = 11'h040, ST_BK_F = 11'h080,
    ST_HOLD = 11'h100, ST_SYNC = 11'h200, ST_DRAIN = 11'h400;
  reg [7:0] pwm_freq_ff, pwm_min_on_ff;
  reg [STEP_W-1:0] scan_step_ff, feed_step_ff;
  reg [10:0] pause_cfg_ff;
  reg [5:0] accel_ff;
  reg [4:0] hold_cfg_ff;
  reg [2:0] ctrl_ff;
  reg [10:0] st_ff;
  reg [2:0] pr_s1_ff, pr_s2_ff, pr_s3_ff;
  wire [1:0] acc_x = accel_ff[`SMPC_AC_X_LSB +: 2];
  wire [1:0] acc_y = accel_ff[`SMPC_AC_Y_LSB +: 2];
  wire [1:0] acc_z = accel_ff[`SMPC_AC_Z_LSB +: 2];
  wire [2:0] lines_after = pause_cfg_ff[`SMPC_PC_LINES_LSB +: 3];
  wire [2:0] rev_steps = pause_cfg_ff[`SMPC_PC_REV_LSB +: 3];
  wire reversing = (rev_steps != 3'h0); // R05 R10
  ////////////////////////////////////////////////////////////////////
  // pins outside the domain: three flops, change taken when 2nd and 3rd agree
  reg pause_q, resume_q, tr_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pr_s1_ff <= 3'h0;
      pr_s2_ff <= 3'h0;
      pr_s3_ff <= 3'h0;
      pause_q <= 1'b0;
      resume_q <= 1'b0;
      tr_q <= 1'b0;
    end else begin
      pr_s1_ff <= {sensor_transfer_pulse, resume_req, pause_req}; // R25
      pr_s2_ff <= pr_s1_ff;
      pr_s3_ff <= pr_s2_ff;
      if (pr_s2_ff[0] == pr_s3_ff[0]) pause_q <= pr_s3_ff[0];
      if (pr_s2_ff[1] == pr_s3_ff[1]) resume_q <= pr_s3_ff[1];
      if (pr_s2_ff[2] == pr_s3_ff[2]) tr_q <= pr_s3_ff[2];
    end
  end
  reg pause_d, resume_d, tr_d;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pause_d <= 1'b0;
      resume_d <= 1'b0;
      tr_d <= 1'b0;
    end else begin
      pause_d <= pause_q;
      resume_d <= resume_q;
      tr_d <= tr_q;
    end
  end
  wire pause_ev = pause_q & ~pause_d;
  wire resume_ev = resume_q & ~resume_d;
  wire tr_ev = tr_q & ~tr_d;
  ////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire acc_ph = psel & penable;
  wire [7:0] ridx = paddr[9:2];
  wire hit = (paddr[1:0] == 2'b00) && (paddr[`SMPC_ADDR_W-1:10] == 2'b00);
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h0;
    rd_ok = hit;
    if (ridx == `SMPC_IDX_PWM_FREQ) rd_mux = {24'h0, pwm_freq_ff};
    else if (ridx == `SMPC_IDX_PWM_MIN_ON) rd_mux = {24'h0, pwm_min_on_ff};
    else if (ridx == `SMPC_IDX_SCAN_STEP) rd_mux = {{(32-STEP_W){1'b0}}, scan_step_ff};
    else if (ridx == `SMPC_IDX_FEED_STEP) rd_mux = {{(32-STEP_W){1'b0}}, feed_step_ff};
    else if (ridx == `SMPC_IDX_PAUSE_CFG) rd_mux = {21'h0, pause_cfg_ff};
    else if (ridx == `SMPC_IDX_ACCEL) rd_mux = {26'h0, accel_ff};
    else if (ridx == `SMPC_IDX_HOLD) rd_mux = {27'h0, hold_cfg_ff};
    else if (ridx == `SMPC_IDX_CTRL) rd_mux = {29'h0, ctrl_ff};
    else if (ridx == `SMPC_IDX_STATUS) rd_mux = {21'h0, st_ff};
    else rd_ok = 1'b0;
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      pwm_freq_ff <= `SMPC_RST_PWM_FREQ;
      pwm_min_on_ff <= `SMPC_RST_PWM_MIN_ON;
      scan_step_ff <= `SMPC_RST_SCAN_STEP;
      feed_step_ff <= `SMPC_RST_FEED_STEP;
      pause_cfg_ff <= 11'h0;
      accel_ff <= 6'h0;
      hold_cfg_ff <= 5'h0;
      ctrl_ff <= 3'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
      if (acc_ph & pready & pwrite & rd_ok) begin
        if (ridx == `SMPC_IDX_PWM_FREQ) pwm_freq_ff <= pwdata[7:0]; // R03
        else if (ridx == `SMPC_IDX_PWM_MIN_ON) pwm_min_on_ff <= pwdata[7:0]; // R03
        else if (ridx == `SMPC_IDX_SCAN_STEP) scan_step_ff <= pwdata[STEP_W-1:0]; // R24
        else if (ridx == `SMPC_IDX_FEED_STEP) feed_step_ff <= pwdata[STEP_W-1:0];
        else if (ridx == `SMPC_IDX_PAUSE_CFG) pause_cfg_ff <= pwdata[10:0];
        else if (ridx == `SMPC_IDX_ACCEL) accel_ff <= pwdata[5:0];
        else if (ridx == `SMPC_IDX_HOLD) hold_cfg_ff <= pwdata[4:0];
        else if (ridx == `SMPC_IDX_CTRL) ctrl_ff <= pwdata[2:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pixel period tick and microstep timer
  reg [7:0] pix_ff;
  wire pix_tick = (pix_ff == `SMPC_DIV_LAST);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pix_ff <= 8'h0;
    else pix_ff <= pix_tick ? 8'h0 : pix_ff + 8'h1;
  end
  // speed multiplier: full 1, half 2, quarter 4
  function [STEP_W+1:0] step_len;
    input [STEP_W-1:0] base;
    input [1:0] mul;
    begin
      step_len = {2'b00, base} << mul; // R15
    end
  endfunction
  reg [1:0] spd;
  always @* begin
    case (st_ff)
      ST_DEC_H, ST_BK_H: spd = 2'd1;
      ST_DEC_Q, ST_BK_Q, ST_STOP: spd = 2'd2;
      default: spd = 2'd0;
    endcase
  end
  wire [STEP_W-1:0] base_step = ctrl_ff[`SMPC_CT_FEED] ? feed_step_ff : scan_step_ff; // R22
  wire [STEP_W+1:0] cur_len = step_len(base_step, spd);
  reg [STEP_W+1:0] tmr_ff;
  reg [STEP_W+1:0] since_step_ff, offset_ff, sync_ff;
  wire moving = (st_ff == ST_RUN) | (st_ff == ST_DRAIN) | (st_ff == ST_DEC_H) | (st_ff == ST_DEC_Q)
    | (st_ff == ST_BK_Q) | (st_ff == ST_BK_H) | (st_ff == ST_BK_F);
  wire timed = moving | (st_ff == ST_STOP);
  wire ustep = timed & pix_tick & (tmr_ff + 1'b1 >= cur_len); // R02 R24
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) tmr_ff <= {(STEP_W+2){1'b0}};
    else if (!timed) tmr_ff <= {(STEP_W+2){1'b0}};
    else if (pix_tick) tmr_ff <= ustep ? {(STEP_W+2){1'b0}} : tmr_ff + 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // motion sequencer
  reg [3:0] tbl_ff; // microstep position, 16 per electrical cycle
  reg [1:0] sub_ff; // microsteps within a full step
  reg [1:0] seg_ff; // full steps left in segment
  reg [2:0] rev_ff;
  reg [2:0] lines_ff;
  reg [4:0] hold_ff;
  reg mid_line_ff;
  wire full_step = ustep & (sub_ff == 2'd3); // R16 R23
  wire dir_back = (st_ff == ST_BK_Q) | (st_ff == ST_BK_H) | (st_ff == ST_BK_F);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_IDLE;
      tbl_ff <= 4'h0;
      sub_ff <= 2'h0;
      seg_ff <= 2'h0;
      rev_ff <= 3'h0;
      lines_ff <= 3'h0;
      hold_ff <= 5'h0;
      since_step_ff <= {(STEP_W+2){1'b0}};
      offset_ff <= {(STEP_W+2){1'b0}};
      sync_ff <= {(STEP_W+2){1'b0}};
      mid_line_ff <= 1'b0;
      line_store_en_ff <= 1'b0;
      line_discard_ff <= 1'b0;
    end else begin
      if (ustep) begin
        tbl_ff <= dir_back ? tbl_ff - 4'h1 : tbl_ff + 4'h1; // R02 R23
        sub_ff <= sub_ff + 2'h1;
        since_step_ff <= {(STEP_W+2){1'b0}};
      end else if (pix_tick) since_step_ff <= since_step_ff + 1'b1;
      if (line_end) line_store_en_ff <= 1'b0;
      if (tr_ev) line_store_en_ff <= ((st_ff == ST_RUN) | (st_ff == ST_DRAIN)) & ~line_discard_ff;
      case (st_ff)
        ST_IDLE: begin
          if (ctrl_ff[`SMPC_CT_RUN]) begin
            st_ff <= ST_RUN; // R20
            line_discard_ff <= 1'b0;
          end
        end
        ST_RUN: begin
          if (!ctrl_ff[`SMPC_CT_RUN]) st_ff <= ST_IDLE;
          else if (pause_ev) begin
            offset_ff <= since_step_ff; // R11
            if (reversing) begin
              st_ff <= ST_DRAIN;
              lines_ff <= 3'h0; // R21
            end else begin
              st_ff <= ST_DRAIN;
              lines_ff <= lines_after; // R06 R07
            end
          end else if (line_discard_ff && line_end) begin
            // drop as many lines as were stored after the pause
            if (lines_ff <= 3'h1) line_discard_ff <= 1'b0; // R09
            lines_ff <= lines_ff - 3'h1;
          end
        end
        ST_DRAIN: begin
          // finish the line in flight, then any extra lines
          if (line_end) begin
            if (lines_ff == 3'h0) begin
              if (reversing) begin
                st_ff <= (acc_z != 2'h0) ? ST_DEC_H : (acc_y != 2'h0) ? ST_DEC_Q : ST_STOP; // R13 R17
                seg_ff <= (acc_z != 2'h0) ? acc_z : acc_y;
              end else begin
                st_ff <= ST_HOLD; // R05
                hold_ff <= hold_cfg_ff;
              end
            end else lines_ff <= lines_ff - 3'h1; // R07
          end
        end
        ST_DEC_H: if (full_step) begin
          if (seg_ff == 2'h1) begin
            st_ff <= (acc_y != 2'h0) ? ST_DEC_Q : ST_STOP;
            seg_ff <= (acc_y != 2'h0) ? acc_y : acc_x;
          end else seg_ff <= seg_ff - 2'h1;
        end
        ST_DEC_Q: if (full_step) begin
          if (seg_ff == 2'h1) begin
            st_ff <= ST_STOP;
            seg_ff <= acc_x;
          end else seg_ff <= seg_ff - 2'h1;
        end
        ST_STOP: begin
          // full step clocks before reversing; zero reverses at once
          if (seg_ff == 2'h0 || full_step) begin // R14
            if (seg_ff <= 2'h1) begin
              st_ff <= (acc_y != 2'h0) ? ST_BK_Q : (acc_z != 2'h0) ? ST_BK_H : ST_BK_F; // R17
              seg_ff <= (acc_y != 2'h0) ? acc_y : acc_z;
              rev_ff <= rev_steps;
            end else seg_ff <= seg_ff - 2'h1;
          end
        end
        ST_BK_Q: if (full_step) begin
          if (seg_ff == 2'h1) begin
            st_ff <= (acc_z != 2'h0) ? ST_BK_H : ST_BK_F;
            seg_ff <= acc_z;
          end else seg_ff <= seg_ff - 2'h1;
        end
        ST_BK_H: if (full_step) begin
          if (seg_ff == 2'h1) st_ff <= ST_BK_F;
          else seg_ff <= seg_ff - 2'h1;
        end
        ST_BK_F: if (full_step) begin
          if (rev_ff == 3'h1) begin
            // no backward decel: full speed reverse goes straight to hold
            st_ff <= ST_HOLD; // R17
            hold_ff <= hold_cfg_ff;
          end else rev_ff <= rev_ff - 3'h1;
        end
        ST_HOLD: begin
          if (pix_tick && hold_ff != 5'h0) hold_ff <= hold_ff - 5'h1; // R18
          if (resume_ev) begin
            st_ff <= ST_SYNC;
            sync_ff <= reversing ? offset_ff : {(STEP_W+2){1'b0}};
            mid_line_ff <= 1'b0;
          end
        end
        ST_SYNC: begin
          // wait next transfer pulse, then the stored offset when reversing
          if (tr_ev) mid_line_ff <= 1'b1;
          if (mid_line_ff && pix_tick) begin
            if (sync_ff == {(STEP_W+2){1'b0}}) begin
              st_ff <= ST_RUN; // R08 R12 R19
              line_discard_ff <= ~reversing & (lines_after != 3'h0); // R09 R21
              lines_ff <= lines_after;
            end else sync_ff <= sync_ff - 1'b1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // sine table and pwm drive
  function [2:0] sine_code;
    input [3:0] pos;
    reg [2:0] m;
    begin
      m = pos[2] ? {1'b0, ~pos[1:0]} + 3'd1 : {1'b0, pos[1:0]};
      sine_code = {pos[3], m[1:0] == 2'b00 && m[2] ? 2'b11 : m[1:0]};
    end
  endfunction
  reg [7:0] pwm_cnt_ff;
  wire pwm_on = (pwm_cnt_ff < pwm_min_on_ff) | ~winding_sense_over; // R03 R04
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pwm_cnt_ff <= 8'h0;
    else pwm_cnt_ff <= (pwm_cnt_ff >= pwm_freq_ff) ? 8'h0 : pwm_cnt_ff + 8'h1;
  end
  wire [3:0] pos_a = tbl_ff;
  wire [3:0] pos_b = tbl_ff + 4'h4;
  wire [2:0] ca = sine_code(pos_a);
  wire [2:0] cb = sine_code(pos_b);
  wire [2:0] ma = (pos_a[1:0] == 2'b00) ? (pos_a[2] ? 3'd4 : 3'd0) : {1'b0, ca[1:0]};
  wire [2:0] mb = (pos_b[1:0] == 2'b00) ? (pos_b[2] ? 3'd4 : 3'd0) : {1'b0, cb[1:0]};
  function [2:0] dac_of;
    input [2:0] mag;
    begin
      case (mag)
        3'd1: dac_of = `SMPC_DAC_L1;
        3'd2: dac_of = `SMPC_DAC_L2;
        3'd3: dac_of = `SMPC_DAC_L3;
        3'd4: dac_of = `SMPC_DAC_L4;
        default: dac_of = `SMPC_DAC_OFF;
      endcase
    end
  endfunction
  wire powered = (st_ff != ST_IDLE) & ~((st_ff == ST_HOLD) & (hold_ff == 5'h0)); // R18
  wire full_mode = ~ctrl_ff[`SMPC_CT_MICRO];
  wire held = (st_ff == ST_HOLD);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_a_ff <= 1'b0;
      phase_an_ff <= 1'b0;
      phase_b_ff <= 1'b0;
      phase_bn_ff <= 1'b0;
      dac_a_ff <= `SMPC_DAC_OFF;
      dac_b_ff <= `SMPC_DAC_OFF;
    end else begin
      phase_a_ff <= powered & pwm_on & (ma != 3'd0) & ~ca[2]; // R01
      phase_an_ff <= powered & pwm_on & (ma != 3'd0) & ca[2]; // R01
      phase_b_ff <= powered & pwm_on & (mb != 3'd0) & ~cb[2];
      phase_bn_ff <= powered & pwm_on & (mb != 3'd0) & cb[2];
      if (!powered) begin
        dac_a_ff <= `SMPC_DAC_OFF;
        dac_b_ff <= `SMPC_DAC_OFF;
      end else if (held & full_mode) begin
        dac_a_ff <= `SMPC_DAC_HOLD; // R18
        dac_b_ff <= `SMPC_DAC_HOLD;
      end else begin
        dac_a_ff <= dac_of(ma); // R01
        dac_b_ff <= dac_of(mb);
      end
    end
  end
endmodule // smpc_stepper_microstep_pause_controller
`default_nettype wire

// *** bench/smpc_motor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smpc_motor_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic phase_a_ff,
  input wire logic phase_an_ff,
  input wire logic [2:0] dac_a_ff,
  output logic winding_sense_over
);
  // winding current rises while driven, decays otherwise; coarse but enough to close the pwm loop
  logic [5:0] cur_ff;
  logic [5:0] nxt_cur;
  always_comb begin
    nxt_cur = cur_ff;
    if (phase_a_ff || phase_an_ff) begin
      if (cur_ff != 6'h3f) nxt_cur = cur_ff + 6'h01;
    end else if (cur_ff != 6'h00) begin
      nxt_cur = cur_ff - 6'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cur_ff <= 6'h00;
    else cur_ff <= nxt_cur;
  end
  assign winding_sense_over = cur_ff > {1'b0, dac_a_ff, 2'b00};
endmodule // smpc_motor_model
`default_nettype wire

// *** bench/smpc_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smpc_defines.vh"
module smpc_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phase_a_ff,
  input wire logic phase_an_ff,
  input wire logic phase_b_ff,
  input wire logic phase_bn_ff,
  input wire logic [2:0] dac_a_ff,
  input wire logic [2:0] dac_b_ff,
  input wire logic line_store_en_ff,
  input wire logic line_discard_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_phase_a_excl: assert property (!(phase_a_ff && phase_an_ff))
    else $error("winding a driven both ways");
  a_phase_b_excl: assert property (!(phase_b_ff && phase_bn_ff))
    else $error("winding b driven both ways");
  a_dac_a_range: assert property (dac_a_ff <= `SMPC_DAC_L4)
    else $error("dac a code out of range");
  a_drive_a_level: assert property ((phase_a_ff || phase_an_ff) |-> dac_a_ff != `SMPC_DAC_OFF)
    else $error("winding a driven with dac off");
  a_dac_step_hold: assert property ($changed(dac_b_ff) |=> $stable(dac_b_ff)[*8])
    else $error("dac b changed faster than one microstep");
  a_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("no answer one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access cycle");
  a_discard_nostore: assert property (line_discard_ff |-> !line_store_en_ff)
    else $error("discarded line marked stored");
  c_err: cover property (pslverr);
  c_store_end: cover property ($fell(line_store_en_ff));
  c_discard: cover property ($rose(line_discard_ff));
  c_neg_phase: cover property (phase_an_ff);
endmodule // smpc_asserts
bind smpc_stepper_microstep_pause_controller smpc_asserts smpc_asserts_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .phase_a_ff(phase_a_ff), .phase_an_ff(phase_an_ff), .phase_b_ff(phase_b_ff),
  .phase_bn_ff(phase_bn_ff), .dac_a_ff(dac_a_ff), .dac_b_ff(dac_b_ff),
  .line_store_en_ff(line_store_en_ff), .line_discard_ff(line_discard_ff));
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smpc_defines.vh"
module tb;
  logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic pause_req = 0, resume_req = 0, sensor_transfer_pulse = 0, line_end = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, winding_sense_over;
  logic phase_a_ff, phase_an_ff, phase_b_ff, phase_bn_ff, line_store_en_ff, line_discard_ff;
  logic [2:0] dac_a_ff, dac_b_ff;
  int miscompares = 0, tests_run = 0, lcnt = 0;
  always #12.5 clk_sys = ~clk_sys;
  // 20 pixel periods per line, transfer pulse one pixel wide
  always @(posedge clk_sys) begin
    lcnt <= (lcnt == 479) ? 0 : lcnt + 1;
    sensor_transfer_pulse <= lcnt < 24;
    line_end <= lcnt == 479;
  end
  smpc_stepper_microstep_pause_controller smpc_stepper_microstep_pause_controller_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pause_req(pause_req), .resume_req(resume_req), .sensor_transfer_pulse(sensor_transfer_pulse),
    .line_end(line_end), .winding_sense_over(winding_sense_over), .phase_a_ff(phase_a_ff),
    .phase_an_ff(phase_an_ff), .phase_b_ff(phase_b_ff), .phase_bn_ff(phase_bn_ff),
    .dac_a_ff(dac_a_ff), .dac_b_ff(dac_b_ff), .line_store_en_ff(line_store_en_ff),
    .line_discard_ff(line_discard_ff));
  smpc_motor_model smpc_motor_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .phase_a_ff(phase_a_ff),
    .phase_an_ff(phase_an_ff), .dac_a_ff(dac_a_ff), .winding_sense_over(winding_sense_over));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("counts run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task timeout;
    miscompares++;
    $display("wait limit reached t=%0t", $time);
    finish_test;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) timeout;
  endtask
  task automatic wait_move(input int lim, output int n);
    logic [5:0] d;
    d = {dac_a_ff, dac_b_ff};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ({dac_a_ff, dac_b_ff} === d && n < lim);
    if (n >= lim) timeout;
  endtask
  task align;
    while (lcnt != 100) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(0, `SMPC_IDX_PWM_FREQ, 0);
    chk(rd, `SMPC_RST_PWM_FREQ);
    apb(0, `SMPC_IDX_PWM_MIN_ON, 0);
    chk(rd, `SMPC_RST_PWM_MIN_ON);
    apb(0, `SMPC_IDX_SCAN_STEP, 0);
    chk(rd, `SMPC_RST_SCAN_STEP);
    apb(0, `SMPC_IDX_FEED_STEP, 0);
    chk(rd, `SMPC_RST_FEED_STEP);
    apb(1, `SMPC_IDX_SCAN_STEP, 32'hffff_ffff);
    apb(0, `SMPC_IDX_SCAN_STEP, 0);
    chk(rd, 32'h0000_3fff);
    apb(1, `SMPC_IDX_PWM_FREQ, 32'h0000_005a);
    // min on-time kept short, only masking switching edges
    apb(1, `SMPC_IDX_PWM_MIN_ON, 32'h0000_0002);
    apb(0, `SMPC_IDX_PWM_FREQ, 0);
    chk(rd, 32'h0000_005a);
    apb(0, 8'h70, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task t_micro;
    int n;
    apb(1, `SMPC_IDX_ACCEL, 32'h0);
    apb(1, `SMPC_IDX_SCAN_STEP, 32'h2);
    apb(1, `SMPC_IDX_HOLD, 32'h1f);
    apb(1, `SMPC_IDX_PAUSE_CFG, 32'h2);
    apb(1, `SMPC_IDX_CTRL, 32'h5);
    wait_move(4000, n);
    // first interval starts mid pixel period, so measure a later one
    wait_move(200, n);
    wait_move(200, n);
    // start goes from idle straight to run, so full speed from the start
    chk(n % 48, 0);
    chk(n <= 96, 1);
    $display("test micro done");
  endtask
  task t_nonrev;
    int c, n, q;
    logic [5:0] d;
    align;
    pause_req <= 1;
    n = 0;
    q = 0;
    // store flag drops briefly between lines; only a long quiet stretch ends it
    for (c = 0; c < 10000 && q < 100; c++) begin
      @(posedge clk_sys);
      if (line_end === 1'b1 && line_store_en_ff === 1'b1) n++;
      q = (line_store_en_ff === 1'b1) ? 0 : q + 1;
    end
    if (c >= 10000) timeout;
    chk(n, 3);
    d = {dac_a_ff, dac_b_ff};
    repeat (100) @(posedge clk_sys);
    chk({dac_a_ff, dac_b_ff}, d);
    pause_req <= 0;
    resume_req <= 1;
    n = 0;
    for (c = 0; c < 20000 && !(n > 0 && line_discard_ff !== 1'b1); c++) begin
      @(posedge clk_sys);
      if (line_end === 1'b1 && line_discard_ff === 1'b1) n++;
    end
    if (c >= 20000) timeout;
    chk(n, 2);
    wait_move(5000, c);
    resume_req <= 0;
    $display("test nonrev done");
  endtask
  task t_rev;
    int c, z, nch;
    logic [5:0] d;
    logic disc;
    apb(1, `SMPC_IDX_PAUSE_CFG, 32'h103);
    apb(1, `SMPC_IDX_HOLD, 32'h2);
    align;
    pause_req <= 1;
    z = 0;
    nch = 0;
    d = {dac_a_ff, dac_b_ff};
    // pwm gaps are short; only a long quiet stretch means drives were cut
    for (c = 0; c < 60000 && z < 200; c++) begin
      @(posedge clk_sys);
      if ({dac_a_ff, dac_b_ff} !== d) nch++;
      d = {dac_a_ff, dac_b_ff};
      z = {phase_a_ff, phase_an_ff, phase_b_ff, phase_bn_ff} === 4'h0 ? z + 1 : 0;
    end
    if (c >= 60000) timeout;
    chk(nch >= 4, 1);
    pause_req <= 0;
    resume_req <= 1;
    disc = 0;
    for (c = 0; c < 1440; c++) begin
      @(posedge clk_sys);
      if (line_discard_ff !== 1'b0) disc = 1;
    end
    chk(disc, 0);
    chk({dac_a_ff, dac_b_ff} !== d, 1);
    resume_req <= 0;
    $display("test rev done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1;
    t_regs;
    t_micro;
    t_nonrev;
    t_rev;
    finish_test;
  end
endmodule // tb
`default_nettype wire
